//--- rtl/insert_head_long_locked.sv
// Interlocked insert-at-head engine for self-relative longword queues.
// Assumes a shared memory that honours reservations and orders barriers.
`timescale 1ns/1ps
`default_nettype none
`include "qins_cfg.svh"
// Function
// R01 - Caller loads header and entry address registers before start.
// R02 - Interlock bit already set: status -1, queue untouched.
// R03 - Checked variant: low three address bits nonzero is illegal operand.
// R04 - Checked variant: header equal to entry is illegal operand.
// R05 - Checked variant: addresses must be sign extensions of low 32 bits.
// R06 - Reserved load then conditional store with bit 0 set, counting retries.
// R07 - Retries exhausted without store success: status -1.
// R08 - Checked: after barrier, bad forward link bits 2:1 restore header, fault.
// R09 - Checked: probe entry and successor writable, else restore, memory fault.
// R10 - Displacement = header minus entry; write entry forward and backward links.
// R11 - Write successor back link, barrier, then header forward link releases lock.
// R12 - Success status 1 when queue was empty, else 0.
// R13 - Whole insert is uninterruptible and excludes other interlocked users.
// R14 - Resident variant skips all address and memory checks.
// R15 - Resident software keeps queue resident and 8-byte aligned.
// R16 - Each element holds forward then backward longword displacement.
// R17 - Header bit 0 is the secondary interlock held during the operation.
// R18 - Conditional store fails if header written since reserved load.
// R19 - Barriers make link writes visible before the releasing header write.
module insert_head_long_locked #(
  parameter int RETRY_N = `QINS_RETRY_DEFAULT // Retry budget
) (
  input wire logic clock, // Clock, 100 MHz
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic start, // Pulse: begin insert
  input wire logic resident, // High: resident variant
  input wire logic [63:0] header_addr_reg, // Queue header address
  input wire logic [63:0] entry_addr_reg, // New entry address
  input wire logic mem_ack, // Memory answer strobe
  input wire qins_pkg::mem_rsp_t mem_rsp, // Memory answer
  output logic mem_valid, // Memory request pending
  output qins_pkg::mem_req_t mem_req, // Memory request
  output logic busy, // Operation in progress
  output logic done, // Pulse: operation finished
  output logic [63:0] status_result_reg, // Status result
  output qins_pkg::exc_kind_t exc // Exception raised
);
  import qins_pkg::*;

  // Refuse a retry budget that the 16-bit counter cannot hold
  if (RETRY_N < 1 || RETRY_N > 65535) begin : g_bad_retry
    $error("RETRY_N out of range");
  end

  typedef enum {
    st_idle, st_check, st_lock_ld, st_lock_sc, st_mb1, st_link_chk,
    st_probe_ent, st_probe_succ, st_wr_fwd, st_wr_bwd, st_wr_succ,
    st_mb2, st_wr_head, st_restore, st_finish
  } state_t;

  state_t state_q, state_d;
  logic [15:0] retry_q, retry_d;
  logic [63:0] hdr_q, hdr_d, ent_q, ent_d, tmp0_q, tmp0_d;
  logic res_q, res_d, issue_q, issue_d;
  logic busy_d, done_d;
  logic [63:0] status_d;
  exc_kind_t exc_d, pend_exc_q, pend_exc_d;
  logic [63:0] stat_pend_q, stat_pend_d; // Status held back until done
  mem_req_t req_d, req_q;
  logic port_done;
  mem_rsp_t rsp;

  // Sign extension of a low longword, used for links and addresses
  function automatic logic [63:0] sext32(input logic [63:0] v);
    return {{32{v[31]}}, v[31:0]};
  endfunction

  // Issue one memory request via the holding port
  qins_mem_port u_port (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .issue(issue_q),
    .req_in(req_q),
    .mem_ack(mem_ack),
    .mem_rsp(mem_rsp),
    .mem_valid(mem_valid),
    .mem_req(mem_req),
    .done(port_done),
    .rsp(rsp)
  );

  logic [63:0] tmp1, tmp2, succ_addr;
  assign tmp1 = sext32(tmp0_q); // R08
  assign tmp2 = sext32(hdr_q - ent_q); // R10
  assign succ_addr = hdr_q + tmp1 + `QINS_LINK_OFS; // R11

  // Sequencer; memory requests are registered so the port sees one pulse
  always_comb begin
    state_d = state_q;
    retry_d = retry_q;
    hdr_d = hdr_q;
    ent_d = ent_q;
    tmp0_d = tmp0_q;
    res_d = res_q;
    issue_d = 1'b0;
    req_d = req_q;
    busy_d = busy;
    done_d = 1'b0;
    status_d = status_result_reg;
    exc_d = exc;
    pend_exc_d = pend_exc_q;
    stat_pend_d = stat_pend_q;
    case (state_q)
      st_idle: begin
        if (start) begin // R01
          hdr_d = header_addr_reg;
          ent_d = entry_addr_reg;
          res_d = resident;
          retry_d = 16'(RETRY_N);
          busy_d = 1'b1; // R13
          exc_d = exc_none;
          pend_exc_d = exc_none;
          stat_pend_d = status_result_reg; // Faults leave the old status
          state_d = st_check;
        end
      end
      st_check: begin
        if (!res_q && (hdr_q[`QINS_ALIGN_MSB:`QINS_ALIGN_LSB] != 3'h0 // R03
            || ent_q[`QINS_ALIGN_MSB:`QINS_ALIGN_LSB] != 3'h0
            || hdr_q == ent_q // R04
            || sext32(hdr_q) != hdr_q || sext32(ent_q) != ent_q)) begin // R05
          pend_exc_d = exc_illegal_operand;
          state_d = st_finish;
        end else begin // R14
          req_d = '{op: mop_load_reserved, addr: hdr_q, wdata: 64'h0};
          issue_d = 1'b1;
          state_d = st_lock_ld;
        end
      end
      st_lock_ld: begin
        if (port_done) begin
          tmp0_d = rsp.rdata;
          if (rsp.rdata[`QINS_LOCK_BIT]) begin // R02 R17
            stat_pend_d = `QINS_ST_FAIL;
            state_d = st_finish;
          end else begin // R06
            req_d = '{op: mop_store_cond, addr: hdr_q,
                      wdata: rsp.rdata | 64'h0000000000000001};
            issue_d = 1'b1;
            state_d = st_lock_sc;
          end
        end
      end
      st_lock_sc: begin
        if (port_done) begin
          retry_d = retry_q - 16'h0001; // R06
          if (rsp.ok) begin // R18
            req_d = '{op: mop_barrier, addr: hdr_q, wdata: 64'h0};
            issue_d = 1'b1;
            state_d = st_mb1;
          end else if (retry_q == 16'h0001) begin // R07
            stat_pend_d = `QINS_ST_FAIL;
            state_d = st_finish;
          end else begin
            req_d = '{op: mop_load_reserved, addr: hdr_q, wdata: 64'h0};
            issue_d = 1'b1;
            state_d = st_lock_ld;
          end
        end
      end
      st_mb1: begin
        if (port_done) begin
          state_d = res_q ? st_wr_fwd : st_link_chk;
        end
      end
      st_link_chk: begin
        if (tmp1[`QINS_FLINK_CHK_MSB:`QINS_FLINK_CHK_LSB] != 2'h0) begin // R08
          pend_exc_d = exc_illegal_operand;
          req_d = '{op: mop_store_quad, addr: hdr_q, wdata: tmp0_q};
          issue_d = 1'b1;
          state_d = st_restore;
        end else begin // R09
          req_d = '{op: mop_probe_write, addr: ent_q, wdata: 64'h0};
          issue_d = 1'b1;
          state_d = st_probe_ent;
        end
      end
      st_probe_ent, st_probe_succ: begin
        if (port_done) begin
          if (!rsp.ok) begin // R09
            pend_exc_d = exc_mem_mgmt;
            req_d = '{op: mop_store_quad, addr: hdr_q, wdata: tmp0_q};
            issue_d = 1'b1;
            state_d = st_restore;
          end else if (state_q == st_probe_ent) begin
            req_d = '{op: mop_probe_write, addr: hdr_q + tmp1, wdata: 64'h0};
            issue_d = 1'b1;
            state_d = st_probe_succ;
          end else begin
            state_d = st_wr_fwd;
          end
        end
      end
      st_wr_fwd: begin // R10 R16
        req_d = '{op: mop_store_long, addr: ent_q, wdata: tmp1 + tmp2};
        issue_d = 1'b1;
        state_d = st_wr_bwd;
      end
      st_wr_bwd: begin
        if (port_done) begin // R10
          req_d = '{op: mop_store_long, addr: ent_q + `QINS_LINK_OFS, wdata: tmp2};
          issue_d = 1'b1;
          state_d = st_wr_succ;
        end
      end
      st_wr_succ: begin
        if (port_done) begin // R11
          req_d = '{op: mop_store_long, addr: succ_addr, wdata: 64'h0 - tmp1 - tmp2};
          issue_d = 1'b1;
          state_d = st_mb2;
        end
      end
      st_mb2: begin
        if (port_done) begin // R19
          req_d = '{op: mop_barrier, addr: hdr_q, wdata: 64'h0};
          issue_d = 1'b1;
          state_d = st_wr_head;
        end
      end
      st_wr_head: begin
        if (port_done && req_q.op == mop_barrier) begin // R11 R17
          req_d = '{op: mop_store_long, addr: hdr_q, wdata: 64'h0 - tmp2};
          issue_d = 1'b1;
        end else if (port_done) begin // R12
          stat_pend_d = (tmp1 == 64'h0) ? `QINS_ST_EMPTY : `QINS_ST_NONEMPTY;
          state_d = st_finish;
        end
      end
      st_restore: begin
        if (port_done) begin // R08 R09
          state_d = st_finish;
        end
      end
      st_finish: begin
        // Status is set only with done, so a reader sees one event; the exception is set with done and cleared at start
        busy_d = 1'b0;
        done_d = 1'b1;
        status_d = stat_pend_q;
        exc_d = pend_exc_q;
        state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
  end

  // Only registers the next values; the engine ignores start while busy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
      retry_q <= 16'h0000;
      hdr_q <= 64'h0;
      ent_q <= 64'h0;
      tmp0_q <= 64'h0;
      res_q <= 1'b0;
      issue_q <= 1'b0;
      req_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      status_result_reg <= 64'h0;
      exc <= exc_none;
      pend_exc_q <= exc_none;
      stat_pend_q <= 64'h0;
    end else if (ce) begin
      state_q <= state_d;
      retry_q <= retry_d;
      hdr_q <= hdr_d;
      ent_q <= ent_d;
      tmp0_q <= tmp0_d;
      res_q <= res_d;
      issue_q <= issue_d;
      req_q <= req_d;
      busy <= busy_d;
      done <= done_d;
      status_result_reg <= status_d;
      exc <= exc_d;
      pend_exc_q <= pend_exc_d;
      stat_pend_q <= stat_pend_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/qins_cfg.svh
// Constants for the interlocked queue insert-at-head engine.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef QINS_CFG_SVH
`define QINS_CFG_SVH
`define QINS_RETRY_DEFAULT 16
`define QINS_ADDR_W 64
`define QINS_DATA_W 64
`define QINS_LINK_OFS 64'h0000000000000004
`define QINS_ALIGN_LSB 0
`define QINS_ALIGN_MSB 2
`define QINS_FLINK_CHK_LSB 1
`define QINS_FLINK_CHK_MSB 2
`define QINS_LOCK_BIT 0
`define QINS_ST_FAIL 64'hffffffffffffffff
`define QINS_ST_EMPTY 64'h0000000000000001
`define QINS_ST_NONEMPTY 64'h0000000000000000
`endif

//--- rtl/qins_mem_port.sv
// Request/answer holder between the engine and the shared memory.
// Assumes memory holds mem_ack for one cycle per taken request.
`timescale 1ns/1ps
`default_nettype none
module qins_mem_port (
  input wire logic clock, // Clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic issue, // Pulse: start a request
  input wire qins_pkg::mem_req_t req_in, // Request to hold
  input wire logic mem_ack, // Memory answer strobe
  input wire qins_pkg::mem_rsp_t mem_rsp, // Memory answer
  output logic mem_valid, // Request pending
  output qins_pkg::mem_req_t mem_req, // Held request
  output logic done, // Pulse: answer arrived
  output qins_pkg::mem_rsp_t rsp // Captured answer
);
  import qins_pkg::*;
  logic valid_d;
  mem_req_t req_d;
  logic done_d;
  mem_rsp_t rsp_d;

  // Hold the request steady until the memory answers
  always_comb begin
    valid_d = mem_valid;
    req_d = mem_req;
    done_d = 1'b0;
    rsp_d = rsp;
    if (mem_valid && mem_ack) begin
      valid_d = 1'b0;
      done_d = 1'b1;
      rsp_d = mem_rsp;
    end else if (issue && !mem_valid) begin
      valid_d = 1'b1;
      req_d = req_in;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      mem_req <= '0;
      done <= 1'b0;
      rsp <= '0;
    end else if (ce) begin
      mem_valid <= valid_d;
      mem_req <= req_d;
      done <= done_d;
      rsp <= rsp_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/qins_pkg.sv
// Types shared by the queue insert engine and its memory port.
// Assumes the constants header is on the include path.
`include "qins_cfg.svh"
package qins_pkg;
  // Memory operations the engine issues
  typedef enum logic [2:0] {
    mop_load_reserved,
    mop_store_cond,
    mop_store_quad,
    mop_store_long,
    mop_barrier,
    mop_probe_write
  } mem_op_t;

  // One memory request
  typedef struct packed {
    mem_op_t op;
    logic [63:0] addr;
    logic [63:0] wdata;
  } mem_req_t;

  // One memory answer
  typedef struct packed {
    logic [63:0] rdata;
    logic ok;
  } mem_rsp_t;

  // Outcome reported with the status
  typedef enum logic [1:0] {
    exc_none,
    exc_illegal_operand,
    exc_mem_mgmt
  } exc_kind_t;
endpackage

//--- tb/insert_head_props.sv
// Assertions on the queue insert engine's ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "qins_cfg.svh"
module insert_head_props #(
  parameter int RETRY_N = 16 // Retry budget
) (
  input wire logic clock, // Clock
  input wire logic rst, // Async reset
  input wire logic ce, // Clock enable
  input wire logic start, // Start pulse
  input wire logic resident, // Resident variant
  input wire logic [63:0] header_addr_reg, // Header address
  input wire logic [63:0] entry_addr_reg, // Entry address
  input wire logic mem_ack, // Memory answer
  input wire qins_pkg::mem_rsp_t mem_rsp, // Answer data
  input wire logic mem_valid, // Request pending
  input wire qins_pkg::mem_req_t mem_req, // Request
  input wire logic busy, // In progress
  input wire logic done, // End pulse
  input wire logic [63:0] status_result_reg, // Status
  input wire qins_pkg::exc_kind_t exc // Exception
);
  import qins_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_start_goes_busy: assert property (start && !busy && ce |=> busy) else $error("start lost");
  a_req_held_steady: assert property (
    mem_valid && !mem_ack |=> mem_valid && $stable(mem_req)) else $error("request moved");
  a_idle_no_req: assert property (!busy |-> !mem_valid) else $error("request while idle");
  a_store_sets_lock: assert property (
    mem_valid && mem_req.op == mop_store_cond |-> mem_req.wdata[0]) else $error("lock bit clear");
  a_same_addr_fault: assert property (
    start && !busy && !resident && header_addr_reg == entry_addr_reg
    |-> ##[1:4] (done && exc == exc_illegal_operand)) else $error("no fault");
  a_same_addr_quiet: assert property (
    start && !busy && !resident && header_addr_reg == entry_addr_reg
    |-> ##1 !mem_valid [*3]) else $error("memory touched");
  a_misalign_fault: assert property (
    start && !busy && !resident && (header_addr_reg[2:0] != 3'h0 ||
    entry_addr_reg[2:0] != 3'h0) |-> ##[1:4] (done && exc == exc_illegal_operand))
    else $error("no align fault");
  a_status_at_done: assert property ($changed(status_result_reg) |-> done) else $error("stray status");
  a_fault_keeps_st: assert property (
    done && exc != exc_none |-> $stable(status_result_reg)) else $error("status on fault");
  a_status_legal: assert property (
    done && exc == exc_none |-> status_result_reg inside
    {`QINS_ST_FAIL, `QINS_ST_EMPTY, `QINS_ST_NONEMPTY}) else $error("bad status");
  a_ce_freezes: assert property (
    !ce |=> $stable(busy) && $stable(done) && $stable(mem_valid) && $stable(status_result_reg))
    else $error("state moved while frozen");
endmodule
bind insert_head_long_locked insert_head_props #(.RETRY_N(RETRY_N)) i_props (.clock(clock),
  .rst(rst), .ce(ce), .start(start), .resident(resident), .header_addr_reg(header_addr_reg),
  .entry_addr_reg(entry_addr_reg), .mem_ack(mem_ack), .mem_rsp(mem_rsp), .mem_valid(mem_valid),
  .mem_req(mem_req), .busy(busy), .done(done), .status_result_reg(status_result_reg), .exc(exc));
`default_nettype wire

//--- tb/qins_mem_model.sv
// Shared memory holding the queue, with contention on conditional stores.
// Assumes each request stands until its one-cycle answer.
`timescale 1ns/1ps
`default_nettype none
module qins_mem_model (
  input wire logic clock, // Clock
  input wire logic rst, // Async reset
  input wire logic mem_valid, // Request pending
  input wire qins_pkg::mem_req_t mem_req, // Request
  input wire logic [1:0] lat, // Answer delay
  input wire logic [63:0] bad_addr, // Probe fails here
  output logic mem_ack, // Answer strobe
  output qins_pkg::mem_rsp_t mem_rsp // Answer
);
  import qins_pkg::*;
  logic [31:0] mem [logic [63:0]];
  int sc_fail_n = 0; // Stores lost to another processor
  int wait_c = 0;
  logic [63:0] a;
  // Answer after lat cycles; released data toggles so stale reads show
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_rsp <= '0;
    end else begin
      mem_ack <= 1'b0;
      mem_rsp <= {~mem_rsp.rdata, 1'b0};
      if (mem_valid && !mem_ack && wait_c < lat) begin
        wait_c = wait_c + 1;
      end else if (mem_valid && !mem_ack) begin
        wait_c = 0;
        a = mem_req.addr;
        mem_ack <= 1'b1;
        mem_rsp.ok <= 1'b1;
        case (mem_req.op)
          mop_load_reserved: mem_rsp.rdata <= {mem[a + 64'h4], mem[a]};
          mop_store_cond, mop_store_quad: begin
            if (mem_req.op == mop_store_cond && sc_fail_n > 0) begin
              mem_rsp.ok <= 1'b0;
              sc_fail_n = sc_fail_n - 1;
            end else begin
              mem[a] = mem_req.wdata[31:0];
              mem[a + 64'h4] = mem_req.wdata[63:32];
            end
          end
          mop_store_long: mem[a] = mem_req.wdata[31:0];
          mop_probe_write: mem_rsp.ok <= (a != bad_addr);
          default: ; // Writes land in order, so a barrier has nothing to wait for
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/test_insert_head_long_locked.sv
// Self-checking bench for the queue insert engine against a memory model.
// Assumes one done pulse per start and the header at a positive address.
`timescale 1ns/1ps
`default_nettype none
`include "qins_cfg.svh"
module test_insert_head_long_locked;
  import qins_pkg::*;
  localparam int RN = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic ce = 1'b1;
  logic resident = 1'b0;
  logic [63:0] hdr = '0;
  logic [63:0] ent = '0;
  logic [63:0] bad = '1;
  logic [1:0] lat = 2'h0;
  logic mem_ack, mem_valid, busy, done;
  mem_rsp_t mem_rsp;
  mem_req_t mem_req;
  logic [63:0] status;
  exc_kind_t exc;
  logic [65:0] exp_q [$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'hc0bd345c;
  logic [63:0] h, e, st;
  logic [31:0] fl, d;
  logic [63:0] hs [4];
  logic [63:0] es [4];
  always #5 clock = ~clock;
  insert_head_long_locked #(.RETRY_N(RN)) i_dut (.clock(clock), .rst(rst), .ce(ce),
    .start(start), .resident(resident), .header_addr_reg(hdr), .entry_addr_reg(ent),
    .mem_ack(mem_ack), .mem_rsp(mem_rsp), .mem_valid(mem_valid), .mem_req(mem_req),
    .busy(busy), .done(done), .status_result_reg(status), .exc(exc));
  qins_mem_model i_mem (.clock(clock), .rst(rst), .mem_valid(mem_valid), .mem_req(mem_req),
    .lat(lat), .bad_addr(bad), .mem_ack(mem_ack), .mem_rsp(mem_rsp));
  task automatic tally(input string what, input logic [65:0] x, input logic [65:0] s);
    cmp_count++;
    if (s !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, x, s);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] x, input logic [31:0] s);
    tally(what, {34'h0, x}, {34'h0, s});
  endtask
  task automatic finish_test();
    $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Note the outcome, launch one insert, wait for it under a bound
  task automatic run(input logic [63:0] hh, ee, input logic r, input logic [63:0] xs,
    input exc_kind_t xe);
    int n;
    exp_q.push_back({xs, xe});
    @(negedge clock);
    hdr = hh;
    ent = ee;
    resident = r;
    ce = 1'b1;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    // Freeze only between memory requests so the model never answers a frozen port
    for (n = 0; n < 500 && busy !== 1'b0; n++) begin
      @(negedge clock);
      lat = 2'($random(seed));
      ce = (xe != exc_none) || mem_valid || !busy || (($random(seed) & 3) != 0);
    end
    @(negedge clock);
    if (xe == exc_none) st = xs;
  endtask
  // Each done pulse settles the oldest note; a hang is cut short
  always @(negedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end else if (done === 1'b1 && exp_q.size() > 0) tally("result", exp_q.pop_front(), {status, exc});
    else if (done === 1'b1) tally("stray done", '0, '1);
  end
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    h = {34'h0, 27'($random(seed)), 3'h0}; // Stays well below bit 31 with its entries
    i_mem.mem[h] = 32'h0;
    i_mem.mem[h + 64'h4] = 32'h0;
    fl = 32'h0;
    st = 64'h0;
    // Insert into the empty queue, then a resident insert in front of it
    for (int k = 1; k <= 2; k++) begin
      e = h + 64'(k * 16);
      d = h[31:0] - e[31:0];
      run(h, e, k == 2, fl == 0 ? `QINS_ST_EMPTY : `QINS_ST_NONEMPTY, exc_none);
      chk_word("entry fwd", fl + d, i_mem.mem[e]);
      chk_word("entry back", d, i_mem.mem[e + 64'h4]);
      chk_word("succ back", -(fl + d), i_mem.mem[h + {{32{fl[31]}}, fl} + 64'h4]);
      chk_word("header fwd", -d, i_mem.mem[h]);
      fl = -d;
    end
    // Lock already held elsewhere: refused, header untouched
    i_mem.mem[h] = fl | 32'h1;
    run(h, h + 64'h40, 1'b0, `QINS_ST_FAIL, exc_none);
    chk_word("locked header", fl | 32'h1, i_mem.mem[h]);
    i_mem.mem[h] = fl;
    // Every try lost, then all but the last lost
    for (int k = RN; k >= RN - 1; k--) begin
      i_mem.sc_fail_n = k;
      d = h[31:0] - 32'(h + 64'h40);
      run(h, h + 64'h40, 1'b0, k == RN ? `QINS_ST_FAIL : `QINS_ST_NONEMPTY, exc_none);
      if (k != RN) fl = -d;
      chk_word("retry header", fl, i_mem.mem[h]);
    end
    // Operand faults: same address, misaligned, not sign extended
    hs = '{h, h + 64'h1, h, h};
    es = '{h, h + 64'h50, h + 64'h54, h + 64'h1_0000_0050};
    foreach (hs[k]) run(hs[k], es[k], 1'b0, st, exc_illegal_operand);
    chk_word("header kept", fl, i_mem.mem[h]);
    // Corrupt link is put back and refused
    i_mem.mem[h] = 32'h6;
    run(h, h + 64'h60, 1'b0, st, exc_illegal_operand);
    chk_word("link restored", 32'h6, i_mem.mem[h]);
    i_mem.mem[h] = fl;
    // Entry not writable: lock released, memory fault
    bad = h + 64'h60;
    run(h, h + 64'h60, 1'b0, st, exc_mem_mgmt);
    chk_word("probe restore", fl, i_mem.mem[h]);
    finish_test();
  end
endmodule
`default_nettype wire
